// File: rtl/dscd_decoder.sv
`timescale 1ns/1ns
module dscd_decoder (
    input wire logic i_clk,
    input wire logic i_reset_n,
    input dscd_pkg::dscd_fetch_t i_fetch,
    output logic o_fetch_ready,
    output dscd_pkg::dscd_decoded_t o_dec,
    output logic o_await_second
);
    import dscd_pkg::*;

    typedef enum logic {
        ST_FIRST,
        ST_SECOND
    } dscd_state_t;

    dscd_state_t state_q;
    dscd_cat_t cat;
    logic is_double;
    logic pc_change;
    logic [1:0] fixed_cycles;
    logic [7:0] opc;
    logic [15:0] opd;
    logic [23:0] first_q;
    logic [1:0] first_cycles_q;
    dscd_decoded_t dec_d;

    // Opcode and operand split of the word at hand
    assign opc = i_fetch.word[OPC_LSB +: OPC_W];
    assign opd = i_fetch.word[15:0];
    assign o_fetch_ready = 1'b1;
    assign o_await_second = (state_q == ST_SECOND);

    dscd_op_class u_class (
        .i_opcode(opc),
        .o_category(cat),
        .o_is_double(is_double),
        .o_pc_change(pc_change),
        .o_fixed_cycles(fixed_cycles)
    );

    // Field extraction per format
    always_comb begin
        dec_d = '0;
        dec_d.valid = i_fetch.valid && !(state_q == ST_FIRST && is_double);
        dec_d.category = cat;
        dec_d.opcode = opc;
        dec_d.is_nop = (opc == OPC_NOP);
        dec_d.full_word = {24'h000000, i_fetch.word};
        dec_d.cycles = fixed_cycles;
        // Conditional test or PC change adds a trailing no-op cycle to a one-cycle instruction
        if (i_fetch.cond_true || pc_change) begin
            if (fixed_cycles == CYC_ONE) begin
                dec_d.cycles = CYC_TWO;
            end
        end
        // Taken skip: cost depends on length of the skipped word
        if (i_fetch.skip_taken) begin
            dec_d.cycles = i_fetch.skipped_double ? CYC_THREE : CYC_TWO;
        end
        unique case (opc[7:4])
            GRP_FILE: begin
                dec_d.byte_mode = opd[F_BYTE];
                dec_d.dest_is_default_file_reg = opd[F_FILE_DEST];
                dec_d.file_addr = opd[12:0];
            end
            GRP_BIT: begin
                dec_d.bit_indirect = opc[3];
                dec_d.bit_pos = opd[F_BITPOS_LSB +: 4];
                dec_d.base_operand_reg = opd[F_BITPOS_LSB +: 4];
                if (opc[2]) begin
                    dec_d.file_addr = {1'b0, opd[11:0]};
                end else begin
                    dec_d.src_mode = opd[F_SRC_MODE_LSB +: 3];
                    dec_d.source_operand_reg = opd[F_REG_LSB +: 4];
                end
            end
            GRP_LIT_W: begin
                dec_d.literal = opd;
                dec_d.base_operand_reg = opc[3:0];
            end
            GRP_LIT_FILE: begin
                dec_d.literal = {8'h00, opc[3:0], opd[15:12]};
                dec_d.file_addr = {1'b0, opd[11:0]};
            end
            GRP_LIT_ALU: begin
                dec_d.base_operand_reg = opc[3:0];
                dec_d.literal = {6'h00, opd[9:0]};
                dec_d.dst_present = opd[F_LITALU_DPRES];
                // Absent destination means the result returns to the base
                if (opd[F_LITALU_DPRES]) begin
                    dec_d.dest_operand_reg = opd[F_LITALU_DREG_LSB +: 4];
                    dec_d.dst_mode = {2'b00, opd[F_LITALU_DMODE]};
                end else begin
                    dec_d.dest_operand_reg = opc[3:0];
                end
            end
            GRP_DSP: begin
                dec_d.acc_b = opc[2];
                if (!opc[3]) begin
                    dec_d.mul_pair = opd[F_MUL_LSB +: 3];
                    dec_d.x_prefetch = opd[F_XPF_LSB +: 4];
                    dec_d.x_dest = opd[F_XD_LSB +: 2];
                    dec_d.y_prefetch = opd[F_YPF_LSB +: 4];
                    dec_d.y_dest = opd[F_YD_LSB +: 2];
                    dec_d.acc_writeback = opd[F_AWB];
                end else begin
                    dec_d.shift_from_reg = opc[1];
                    dec_d.src_mode = opd[F_DST_MODE_LSB +: 3];
                    dec_d.source_operand_reg = opd[F_DST_REG_LSB +: 4];
                    dec_d.shift_amount_reg = opd[3:0];
                    dec_d.shift_literal = opd[5:0];
                end
            end
            GRP_CTRL0, GRP_CTRL3: begin
                dec_d.prog_addr = {7'h00, opd};
                dec_d.table_mode = opd[F_TBL_MODE_LSB +: 2];
                dec_d.source_operand_reg = opd[F_REG_LSB +: 4];
            end
            default: begin
                dec_d.byte_mode = opd[F_BYTE];
                dec_d.base_operand_reg = opc[3:0];
                dec_d.dst_mode = opd[F_DST_MODE_LSB +: 3];
                dec_d.dest_operand_reg = opd[F_DST_REG_LSB +: 4];
                dec_d.src_mode = opd[F_SRC_MODE_LSB +: 3];
                dec_d.source_operand_reg = opd[F_REG_LSB +: 4];
            end
        endcase
        // Second word completes a held double-word instruction
        if (state_q == ST_SECOND) begin
            dec_d = '0;
            dec_d.valid = i_fetch.valid;
            dec_d.category = (first_q[23:20] == GRP_CTRL0) ? CAT_CONTROL : CAT_LITERAL;
            dec_d.opcode = first_q[OPC_LSB +: OPC_W];
            dec_d.is_double = 1'b1;
            dec_d.cycles = first_cycles_q;
            dec_d.full_word = {first_q, i_fetch.word};
            dec_d.prog_addr = {i_fetch.word[6:0], first_q[15:0]};
            dec_d.literal = first_q[15:0];
            dec_d.file_addr = i_fetch.word[12:0];
        end
    end

    // Word sequencing for double-word instructions
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            state_q <= ST_FIRST;
        end else if (i_fetch.valid) begin
            unique case (state_q)
                ST_FIRST: state_q <= is_double ? ST_SECOND : ST_FIRST;
                ST_SECOND: state_q <= ST_FIRST;
            endcase
        end
    end

    // Holding of the first word
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            first_q <= '0;
            first_cycles_q <= CYC_ONE;
        end else if (i_fetch.valid && state_q == ST_FIRST && is_double) begin
            first_q <= i_fetch.word;
            first_cycles_q <= fixed_cycles;
        end
    end

    // Registered decode result
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_dec <= '0;
        end else begin
            o_dec <= dec_d;
        end
    end

endmodule : dscd_decoder

// File: rtl/dscd_pkg.sv
// Contract
// - Each single-word instruction is 24 bits: an 8-bit opcode and then the operand fields.
// - The three double-word instructions are assembled from both words, 48 bits, before issue.
// - A second word has a zero top byte and executes as a no-operation when reached alone.
// - Every double-word instruction takes two instruction cycles.
// - Most single-word instructions take one cycle, or two with a trailing no-op on a true test or PC change.
// - Working-register word/byte operations decode base, modified source and modified destination.
// - File-register operations decode a file address and a destination of file or register zero.
// - Bit operations decode a register or file operand and a bit position, literal or from the base register.
// - Literal moves decode the literal and the working or file register that receives it.
// - Literal arithmetic decodes a base source, a literal and a destination present only when it differs.
// - Multiply-accumulate decodes accumulator, operand pair, X/Y prefetches with destinations and write-back.
// - Other signal-processing operations decode accumulator, modified operand and a register or literal shift.
// - Control operations decode a program address and a table read/write mode where applicable.
// - Every instruction is put in one of five categories.
// - Relative branch, indirect call/jump, table access and returns are single-word but take two or three cycles.
// - A taken skip costs two cycles over a single-word and three over a double-word; double moves take two.
package dscd_pkg;

    localparam int WORD_W = 24;
    localparam int OPC_W = 8;
    localparam int OPC_LSB = 16;

    // Opcode map of this core
    localparam logic [7:0] OPC_NOP = 8'h00;
    localparam logic [7:0] OPC_IND_JUMP = 8'h01;
    localparam logic [7:0] OPC_CALL_LONG = 8'h02;
    localparam logic [7:0] OPC_GOTO_LONG = 8'h04;
    localparam logic [7:0] OPC_MOV_DOUBLE = 8'h06;
    localparam logic [7:0] OPC_TABLE_RD = 8'h0a;
    localparam logic [7:0] OPC_TABLE_WR = 8'h0b;
    localparam logic [7:0] OPC_RETURN = 8'h0e;
    localparam logic [7:0] OPC_RET_FROM_INT = 8'h0f;  // return_from_interrupt_op
    localparam logic [7:0] OPC_COND_BRANCH = 8'h31;
    localparam logic [7:0] OPC_REL_BRANCH = 8'h37;   // relative_branch_op
    localparam logic [7:0] OPC_BIT_SKIP = 8'ha6;

    // Category selected by the opcode high nibble
    localparam logic [3:0] GRP_CTRL0 = 4'h0;
    localparam logic [3:0] GRP_LIT_FILE = 4'h2;
    localparam logic [3:0] GRP_CTRL3 = 4'h3;
    localparam logic [3:0] GRP_LIT_W = 4'h8;
    localparam logic [3:0] GRP_LIT_ALU = 4'h9;
    localparam logic [3:0] GRP_BIT = 4'ha;
    localparam logic [3:0] GRP_FILE = 4'hb;
    localparam logic [3:0] GRP_DSP = 4'hc;

    // Cycle counts
    localparam logic [1:0] CYC_ONE = 2'h1;
    localparam logic [1:0] CYC_TWO = 2'h2;
    localparam logic [1:0] CYC_THREE = 2'h3;

    // Operand field positions within the low 16 bits
    localparam int F_BYTE = 15;
    localparam int F_DST_MODE_LSB = 12;
    localparam int F_DST_REG_LSB = 8;
    localparam int F_SRC_MODE_LSB = 4;
    localparam int F_REG_LSB = 0;
    localparam int F_FILE_DEST = 13;
    localparam int F_BITPOS_LSB = 12;
    localparam int F_LITALU_DPRES = 15;
    localparam int F_LITALU_DREG_LSB = 11;
    localparam int F_LITALU_DMODE = 10;
    localparam int F_MUL_LSB = 13;
    localparam int F_XPF_LSB = 9;
    localparam int F_XD_LSB = 7;
    localparam int F_YPF_LSB = 3;
    localparam int F_YD_LSB = 1;
    localparam int F_AWB = 0;
    localparam int F_TBL_MODE_LSB = 14;

    typedef enum logic [2:0] {
        CAT_WORD_BYTE,
        CAT_BIT,
        CAT_LITERAL,
        CAT_DSP,
        CAT_CONTROL
    } dscd_cat_t;

    typedef struct packed {
        logic valid;
        logic [23:0] word;
        logic cond_true;       // Conditional test of this word is true
        logic skip_taken;      // Skip of this word is performed
        logic skipped_double;  // Word being skipped is double-word
    } dscd_fetch_t;

    typedef struct packed {
        logic valid;
        dscd_cat_t category;
        logic [7:0] opcode;
        logic is_nop;
        logic is_double;
        logic [1:0] cycles;
        logic byte_mode;
        logic [3:0] base_operand_reg;
        logic [3:0] source_operand_reg;
        logic [2:0] src_mode;
        logic [3:0] dest_operand_reg;
        logic [2:0] dst_mode;
        logic dst_present;
        logic [12:0] file_addr;
        logic dest_is_default_file_reg;
        logic [3:0] bit_pos;
        logic bit_indirect;
        logic [15:0] literal;
        logic acc_b;
        logic [2:0] mul_pair;
        logic [3:0] x_prefetch;
        logic [1:0] x_dest;
        logic [3:0] y_prefetch;
        logic [1:0] y_dest;
        logic acc_writeback;
        logic shift_from_reg;
        logic [3:0] shift_amount_reg;
        logic [5:0] shift_literal;
        logic [1:0] table_mode;
        logic [22:0] prog_addr;
        logic [47:0] full_word;
    } dscd_decoded_t;

endpackage : dscd_pkg

// File: rtl/dscd_op_class.sv
`timescale 1ns/1ns
module dscd_op_class (
    input wire logic [7:0] i_opcode,
    output dscd_pkg::dscd_cat_t o_category,
    output logic o_is_double,
    output logic o_pc_change,
    output logic [1:0] o_fixed_cycles
);
    import dscd_pkg::*;

    // Category from the opcode high nibble
    always_comb begin
        unique case (i_opcode[7:4])
            GRP_CTRL0, GRP_CTRL3: o_category = CAT_CONTROL;
            GRP_LIT_W, GRP_LIT_FILE, GRP_LIT_ALU: o_category = CAT_LITERAL;
            GRP_BIT: o_category = CAT_BIT;
            GRP_DSP: o_category = CAT_DSP;
            default: o_category = CAT_WORD_BYTE;
        endcase
    end

    // Length and fixed cycle cost
    always_comb begin
        o_is_double = 1'b0;
        o_pc_change = 1'b0;
        o_fixed_cycles = CYC_ONE;
        unique case (i_opcode)
            OPC_CALL_LONG, OPC_GOTO_LONG, OPC_MOV_DOUBLE: begin
                o_is_double = 1'b1;
                o_fixed_cycles = CYC_TWO;
            end
            OPC_REL_BRANCH, OPC_IND_JUMP, OPC_TABLE_RD, OPC_TABLE_WR: begin
                o_pc_change = 1'b1;
                o_fixed_cycles = CYC_TWO;
            end
            OPC_RETURN, OPC_RET_FROM_INT: begin
                o_pc_change = 1'b1;
                o_fixed_cycles = CYC_THREE;
            end
            default: o_fixed_cycles = CYC_ONE;
        endcase
    end

endmodule : dscd_op_class

// File: tb/dscd_decoder_assertions.sv
`timescale 1ns/1ns
module dscd_decoder_checker (
    input wire logic i_clk,
    input wire logic i_reset_n,
    input dscd_pkg::dscd_fetch_t i_fetch,
    input wire logic o_fetch_ready,
    input dscd_pkg::dscd_decoded_t o_dec,
    input wire logic o_await_second
);
    import dscd_pkg::*;
    logic [7:0] opc;
    logic first_ok;
    logic dbl_op;
    // Opcode of the fetch and whether it starts a new instruction
    assign opc = i_fetch.word[23:16];
    assign first_ok = i_fetch.valid && !o_await_second;
    assign dbl_op = opc inside {OPC_CALL_LONG, OPC_GOTO_LONG, OPC_MOV_DOUBLE};
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_reset_n);
    // Steps of a two-word transfer
    sequence s_first;
        first_ok && dbl_op;
    endsequence
    sequence s_second;
        i_fetch.valid;
    endsequence
    AST_SINGLE: assert property (first_ok && !dbl_op |=> o_dec.valid && o_dec.opcode == $past(opc))
        else $error("single word not decoded next cycle");
    AST_NO_SPUR: assert property (o_dec.valid |-> $past(i_fetch.valid))
        else $error("decode without a fetch");
    AST_FIRST_HELD: assert property (s_first |=> o_await_second && !o_dec.valid)
        else $error("first word not held");
    AST_PAIR: assert property (s_first ##1 s_second |=> o_dec.valid && o_dec.is_double && o_dec.cycles == CYC_TWO && !o_await_second)
        else $error("double word not issued as two cycles");
    AST_PAIR_LOW: assert property (o_await_second && i_fetch.valid |=> o_dec.full_word[23:0] == $past(i_fetch.word))
        else $error("second word lost");
    AST_LONE_NOP: assert property (first_ok && opc == OPC_NOP && !i_fetch.cond_true && !i_fetch.skip_taken |=> o_dec.is_nop && o_dec.cycles == CYC_ONE)
        else $error("lone second word not a nop");
    AST_COND: assert property (first_ok && opc == OPC_COND_BRANCH && i_fetch.cond_true && !i_fetch.skip_taken |=> o_dec.cycles == CYC_TWO)
        else $error("true test not two cycles");
    AST_REL: assert property (first_ok && opc == OPC_REL_BRANCH && !i_fetch.skip_taken |=> o_dec.cycles == CYC_TWO)
        else $error("relative branch not two cycles");
    AST_SKIP: assert property (first_ok && !dbl_op && i_fetch.skip_taken |=> o_dec.cycles == ($past(i_fetch.skipped_double) ? CYC_THREE : CYC_TWO))
        else $error("skip cycle count wrong");
endmodule : dscd_decoder_checker

// File: tb/dscd_fetch_model.sv
`timescale 1ns/1ns
module dscd_fetch_model (
    output dscd_pkg::dscd_fetch_t o_fetch
);
    import dscd_pkg::*;
    // Nothing presented until the first word
    initial o_fetch = '0;
    // Present one word with its flags
    task automatic drive(input logic [23:0] w, input logic c, s, d);
        o_fetch = '{valid: 1'b1, word: w, cond_true: c, skip_taken: s, skipped_double: d};
    endtask : drive
    // Drop valid; word flips so stale data never looks fresh
    task automatic release_bus();
        o_fetch.valid = 1'b0;
        o_fetch.word = ~o_fetch.word;
    endtask : release_bus
endmodule : dscd_fetch_model

// File: tb/dsc_instruction_word_decoder_test.sv
`timescale 1ns/1ns
module dsc_instruction_word_decoder_test;
    import dscd_pkg::*;
    logic i_clk = 1'b0;
    logic i_reset_n = 1'b0;
    dscd_fetch_t fetch;
    logic ready;
    dscd_decoded_t dec;
    logic await2;
    int bad_count = 0;
    int check_count = 0;
    logic [23:0] w1, w2;
    logic [3:0] nib;
    logic [7:0] ops[6] = '{OPC_IND_JUMP, OPC_TABLE_RD, OPC_TABLE_WR, OPC_RETURN,
        OPC_RET_FROM_INT, OPC_REL_BRANCH};
    logic [7:0] dops[3] = '{OPC_CALL_LONG, OPC_GOTO_LONG, OPC_MOV_DOUBLE};

    always #4 i_clk = ~i_clk;

    dscd_fetch_model fm (.o_fetch(fetch));
    dscd_decoder dut (.i_clk(i_clk), .i_reset_n(i_reset_n), .i_fetch(fetch),
        .o_fetch_ready(ready), .o_dec(dec), .o_await_second(await2));

    task automatic check(input logic [47:0] seen, input logic [47:0] exp);
        check_count++;
        if (seen !== exp) begin
            bad_count++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    task automatic summarize();
        $display("checks=%0d mismatches=%0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : summarize

    // Word taken at the next edge; o_dec settled on return
    task automatic send(input logic [23:0] w, input logic c, s, d);
        fm.drive(w, c, s, d);
        @(posedge i_clk);
        #1;
    endtask : send

    function automatic dscd_cat_t exp_cat(input logic [7:0] op);
        case (op[7:4])
            4'h0, 4'h3: return CAT_CONTROL;
            4'h2, 4'h8, 4'h9: return CAT_LITERAL;
            4'ha: return CAT_BIT;
            4'hc: return CAT_DSP;
            default: return CAT_WORD_BYTE;
        endcase
    endfunction : exp_cat

    function automatic logic [1:0] exp_cyc(input logic [7:0] op, input logic c, s, d);
        logic [1:0] n;
        n = (op inside {OPC_IND_JUMP, OPC_TABLE_RD, OPC_TABLE_WR, OPC_REL_BRANCH}) ? CYC_TWO : CYC_ONE;
        if (op inside {OPC_RETURN, OPC_RET_FROM_INT}) n = CYC_THREE;
        if (n == CYC_ONE && c) n = CYC_TWO;
        if (s) n = d ? CYC_THREE : CYC_TWO;
        return n;
    endfunction : exp_cyc

    task automatic single(input logic [23:0] w, input logic c, s, d);
        send(w, c, s, d);
        check(dec.valid, 1'b1);
        check(dec.opcode, w[23:16]);
        check(dec.category, exp_cat(w[23:16]));
        check(dec.cycles, exp_cyc(w[23:16], c, s, d));
    endtask : single

    task automatic dbl(input logic [23:0] a, b);
        send(a, 1'b0, 1'b0, 1'b0);
        check(await2, 1'b1);
        check(dec.valid, 1'b0);
        send(b, 1'b0, 1'b0, 1'b0);
        check(dec.full_word, {a, b});
        check(dec.prog_addr, {b[6:0], a[15:0]});
        check(dec.literal, a[15:0]);
        check(dec.file_addr, b[12:0]);
        check(dec.category, CAT_CONTROL);
        check(dec.is_double, 1'b1);
        check(dec.cycles, CYC_TWO);
        check(await2, 1'b0);
    endtask : dbl

    // Hang guard
    initial begin
        #(8 * 5000);
        bad_count++;
        summarize();
    end

    // Test sequence
    initial begin
        void'($urandom(32'h112f65f6));
        repeat (16) @(posedge i_clk);
        #1;
        i_reset_n = 1'b1;
        single(24'h1234ab, 1'b0, 1'b0, 1'b0);
        $display("walk done");
        foreach (dops[i]) begin
            w1 = 24'($urandom);
            w2 = 24'($urandom);
            w1[23:16] = dops[i];
            w2[23:16] = 8'h00;
            dbl(w1, w2);
        end
        $display("double words done");
        single(24'h00c3a5, 1'b0, 1'b0, 1'b0);
        check(dec.is_nop, 1'b1);
        $display("lone second word done");
        foreach (ops[i]) single({ops[i], 16'h5a5a}, 1'b0, 1'b0, 1'b0);
        single({OPC_COND_BRANCH, 16'h0010}, 1'b1, 1'b0, 1'b0);
        single({OPC_BIT_SKIP, 16'h3001}, 1'b0, 1'b1, 1'b0);
        single({OPC_BIT_SKIP, 16'h3001}, 1'b0, 1'b1, 1'b1);
        $display("cycle counts done");
        check(ready, 1'b1);
        single(24'h4ca519, 1'b0, 1'b0, 1'b0);
        check(dec.byte_mode, 1'b1);
        check(dec.base_operand_reg, 4'hc);
        check(dec.dst_mode, 3'h2);
        check(dec.dest_operand_reg, 4'h5);
        check(dec.src_mode, 3'h1);
        check(dec.source_operand_reg, 4'h9);
        single(24'hb0a123, 1'b0, 1'b0, 1'b0);
        check(dec.byte_mode, 1'b1);
        check(dec.dest_is_default_file_reg, 1'b1);
        check(dec.file_addr, 13'h0123);
        single(24'ha87035, 1'b0, 1'b0, 1'b0);
        check(dec.bit_indirect, 1'b1);
        check(dec.bit_pos, 4'h7);
        check(dec.src_mode, 3'h3);
        check(dec.source_operand_reg, 4'h5);
        single(24'ha47abc, 1'b0, 1'b0, 1'b0);
        check(dec.bit_indirect, 1'b0);
        check(dec.file_addr, 13'h0abc);
        single(24'h93a9ff, 1'b0, 1'b0, 1'b0);
        check(dec.base_operand_reg, 4'h3);
        check(dec.dst_present, 1'b1);
        check(dec.dest_operand_reg, 4'h5);
        check(dec.literal, 16'h01ff);
        single(24'h930123, 1'b0, 1'b0, 1'b0);
        check(dec.dst_present, 1'b0);
        check(dec.dest_operand_reg, 4'h3);
        single(24'hc46a5b, 1'b0, 1'b0, 1'b0);
        check(dec.acc_b, 1'b1);
        check(dec.mul_pair, 3'h3);
        check(dec.x_prefetch, 4'h5);
        check(dec.x_dest, 2'h0);
        check(dec.y_prefetch, 4'hb);
        check(dec.y_dest, 2'h1);
        check(dec.acc_writeback, 1'b1);
        single(24'hca3c25, 1'b0, 1'b0, 1'b0);
        check(dec.acc_b, 1'b0);
        check(dec.shift_from_reg, 1'b1);
        check(dec.src_mode, 3'h3);
        check(dec.source_operand_reg, 4'hc);
        check(dec.shift_amount_reg, 4'h5);
        check(dec.shift_literal, 6'h25);
        single({OPC_TABLE_RD, 16'hc001}, 1'b0, 1'b0, 1'b0);
        check(dec.table_mode, 2'h3);
        check(dec.prog_addr, 23'h00c001);
        $display("operand fields done");
        repeat (300) begin
            nib = 4'($urandom_range(15, 1));
            if (nib == 4'h3) nib = 4'h4;
            w1 = 24'($urandom);
            w1[23:20] = nib;
            single(w1, 1'($urandom), 1'($urandom), 1'($urandom));
            if ($urandom_range(3, 0) == 0) begin
                fm.release_bus();
                @(posedge i_clk);
                #1;
            end
        end
        $display("random words done");
        send({OPC_GOTO_LONG, 16'h1234}, 1'b0, 1'b0, 1'b0);
        i_reset_n = 1'b0;
        fm.release_bus();
        #1;
        check(await2, 1'b0);
        check(dec.valid, 1'b0);
        @(posedge i_clk);
        #1;
        i_reset_n = 1'b1;
        single(24'h0077ee, 1'b0, 1'b0, 1'b0);
        check(dec.is_double, 1'b0);
        $display("reset mid pair done");
        summarize();
    end
endmodule : dsc_instruction_word_decoder_test

bind dscd_decoder dscd_decoder_checker u_chk (.i_clk(i_clk), .i_reset_n(i_reset_n),
    .i_fetch(i_fetch), .o_fetch_ready(o_fetch_ready), .o_dec(o_dec),
    .o_await_second(o_await_second));
